// ==== src/tpid_top.sv ====
// AHB-Lite slave returning the trace port identification words
`timescale 1ns/1ns
// What this block does
// - Capability bit 17 reads 1 (parallel port follows the prescaler), forced 0 if bit 9 were 1.
// - Capability bit 11 reads 1, serial NRZ output supported.
// - Capability bit 10 reads 1, serial Manchester output supported.
// - Capability bit 9 reads 0, parallel clock plus data port supported.
// - Capability bits 8 to 6 read 0b000, FIFO depth implementation defined.
// - Capability bit 5 reads 1, register and trace clocks may be asynchronous.
// - Capability bits 4 to 0 read 0, a single trace input.
// - Reserved bits of every word read as zero and writes to them have no effect.
// - The device-type word reads 0x00000011.
// - Bits 7 to 4 of identification word 4 read 0, size unknown.
// - Bits 3 to 0 of identification word 4 hold the manufacturer continuation code.
// - Identification words 5, 6 and 7 read all zeros.
// - Bits 7 to 0 of identification word 0 hold the low part number byte.
// - Capability, type and identification word 0 decode as 32-bit read-only words.
module tpid_top
  import tpid_pkg::*;
#(
  parameter logic [3:0] CONT_CODE = 4'h0,  // Arbitrary value
  parameter logic [7:0] PART_LOW = 8'h5a   // Arbitrary value
) (
  // Clock, reset, enable
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [31:0] rdata;
    logic [11:0] addr;
    logic rd_pend;
  } tpid_state_t;

  tpid_state_t s_q;
  tpid_state_t s_d;
  tpid_rd_if rd();
  logic valid_req;

  tpid_regfile #(.CONT_CODE(CONT_CODE), .PART_LOW(PART_LOW)) u_regs (.rd(rd));

  // Data is fetched a cycle late so hrdata comes from a flop; costs one wait state on reads
  assign valid_req = hsel & hready & htrans[1];
  assign rd.addr = s_q.addr;

  always_comb begin
    s_d = s_q;
    s_d.rd_pend = 1'b0;
    if (valid_req && !hwrite) begin
      s_d.addr = {haddr[11:2], 2'b00};
      s_d.rd_pend = 1'b1;
    end
    if (s_q.rd_pend) begin
      // Unmapped words read as zero
      s_d.rdata = rd.hit ? rd.data : TPID_VAL_ZERO;
    end else if (valid_req) begin
      s_d.rdata = TPID_VAL_ZERO;
    end
    // Writes complete with no wait, store nothing and clear hrdata to zero
    if (valid_req && hwrite) begin
      s_d.addr = s_q.addr;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '0;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  // Held low while frozen so the master waits instead of losing its transfer;
  // another slave's ready seen during a freeze can still drop one, a known limit
  assign hreadyout = ~s_q.rd_pend & clk_en;
  assign hresp = 1'b0;
  assign hrdata = s_q.rdata;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // A pending read that moves at this edge shows its word on hrdata one edge later
  logic rd_fire;
  logic rd_cap;
  logic rd_type;
  logic rd_id4;
  logic rd_id5;
  logic rd_id6;
  logic rd_id7;
  logic rd_id0;
  logic rd_unmapped;
  assign rd_fire = clk_en & s_q.rd_pend;
  assign rd_cap = rd_fire & (s_q.addr == TPID_OFS_DEVICE_CAPABILITIES);
  assign rd_type = rd_fire & (s_q.addr == TPID_OFS_DEVICE_TYPE_CODE);
  assign rd_id4 = rd_fire & (s_q.addr == TPID_OFS_PERIPHERAL_IDENT_WORD4);
  assign rd_id5 = rd_fire & (s_q.addr == TPID_OFS_PERIPHERAL_IDENT_WORD5);
  assign rd_id6 = rd_fire & (s_q.addr == TPID_OFS_PERIPHERAL_IDENT_WORD6);
  assign rd_id7 = rd_fire & (s_q.addr == TPID_OFS_PERIPHERAL_IDENT_WORD7);
  assign rd_id0 = rd_fire & (s_q.addr == TPID_OFS_PERIPHERAL_IDENT_WORD0);
  assign rd_unmapped = rd_fire & ~(rd_cap | rd_type | rd_id4 | rd_id5 | rd_id6 | rd_id7 | rd_id0);

  property p_cap_value;
    @(posedge hclk) disable iff (!hresetn)
    (clk_en && s_q.rd_pend && s_q.addr == TPID_OFS_DEVICE_CAPABILITIES) |=> (hrdata == 32'h0002_0c20);
  endproperty
  a_cap_value: assert property (p_cap_value) else $error("capability word wrong");
  property p_type_value;
    @(posedge hclk) disable iff (!hresetn)
    (clk_en && s_q.rd_pend && s_q.addr == TPID_OFS_DEVICE_TYPE_CODE) |=> (hrdata == 32'h0000_0011);
  endproperty
  a_type_value: assert property (p_type_value) else $error("type word wrong");
  property p_id4_value;
    @(posedge hclk) disable iff (!hresetn)
    (clk_en && s_q.rd_pend && s_q.addr == TPID_OFS_PERIPHERAL_IDENT_WORD4)
      |=> (hrdata == {24'h0, 4'h0, CONT_CODE});
  endproperty
  a_id4_value: assert property (p_id4_value) else $error("ident word 4 wrong");
  property p_id567_zero;
    @(posedge hclk) disable iff (!hresetn)
    (clk_en && s_q.rd_pend && s_q.addr inside {12'hfd4, 12'hfd8, 12'hfdc}) |=> (hrdata == 32'h0);
  endproperty
  a_id567_zero: assert property (p_id567_zero) else $error("ident word 5-7 nonzero");
  property p_id0_value;
    @(posedge hclk) disable iff (!hresetn)
    (clk_en && s_q.rd_pend && s_q.addr == TPID_OFS_PERIPHERAL_IDENT_WORD0)
      |=> (hrdata == {24'h0, PART_LOW});
  endproperty
  a_id0_value: assert property (p_id0_value) else $error("ident word 0 wrong");
  property p_read_wait;
    @(posedge hclk) disable iff (!hresetn)
    (clk_en && valid_req && !hwrite) |=> !hreadyout;
  endproperty
  a_read_wait: assert property (p_read_wait) else $error("read wait not one cycle");
  property p_write_nowait;
    @(posedge hclk) disable iff (!hresetn)
    (clk_en && valid_req && hwrite) |=> ((hreadyout == clk_en) && $stable(s_q.addr));
  endproperty
  a_write_nowait: assert property (p_write_nowait) else $error("write stalled or stored");
  property p_resp_okay;
    @(posedge hclk) disable iff (!hresetn)
    hresp == 1'b0;
  endproperty
  a_resp_okay: assert property (p_resp_okay) else $error("error response");
  property p_reserved_zero;
    @(posedge hclk) disable iff (!hresetn)
    (hrdata[31:18] == 14'h0) && (hrdata[16:12] == 5'h0);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");

  // ----------------------------------------
  // Capability fields
  // ----------------------------------------
  property p_cap_presc;
    @(posedge hclk) disable iff (!hresetn)
    rd_cap |=> hrdata[17] == 1'b1;
  endproperty
  a_cap_presc: assert property (p_cap_presc) else $error("bit 17 wrong");

  property p_cap_nrz;
    @(posedge hclk) disable iff (!hresetn)
    rd_cap |=> hrdata[11] == 1'b1;
  endproperty
  a_cap_nrz: assert property (p_cap_nrz) else $error("bit 11 wrong");

  property p_cap_manch;
    @(posedge hclk) disable iff (!hresetn)
    rd_cap |=> hrdata[10] == 1'b1;
  endproperty
  a_cap_manch: assert property (p_cap_manch) else $error("bit 10 wrong");

  property p_cap_par;
    @(posedge hclk) disable iff (!hresetn)
    rd_cap |=> hrdata[9] == 1'b0;
  endproperty
  a_cap_par: assert property (p_cap_par) else $error("bit 9 wrong");

  property p_cap_fifo;
    @(posedge hclk) disable iff (!hresetn)
    rd_cap |=> hrdata[8:6] == 3'h0;
  endproperty
  a_cap_fifo: assert property (p_cap_fifo) else $error("fifo depth wrong");

  property p_cap_clk;
    @(posedge hclk) disable iff (!hresetn)
    rd_cap |=> hrdata[5] == 1'b1;
  endproperty
  a_cap_clk: assert property (p_cap_clk) else $error("bit 5 wrong");

  property p_cap_mux;
    @(posedge hclk) disable iff (!hresetn)
    rd_cap |=> hrdata[4:0] == 5'h00;
  endproperty
  a_cap_mux: assert property (p_cap_mux) else $error("mux count wrong");

  property p_cap_resv;
    @(posedge hclk) disable iff (!hresetn)
    rd_cap |=> hrdata[31:18] == 14'h0 && hrdata[16:12] == 5'h0;
  endproperty
  a_cap_resv: assert property (p_cap_resv) else $error("cap reserved set");

  // ----------------------------------------
  // Type and identification words
  // ----------------------------------------
  property p_type_major;
    @(posedge hclk) disable iff (!hresetn)
    rd_type |=> hrdata[3:0] == 4'h1;
  endproperty
  a_type_major: assert property (p_type_major) else $error("major type wrong");

  property p_type_sub;
    @(posedge hclk) disable iff (!hresetn)
    rd_type |=> hrdata[7:4] == 4'h1;
  endproperty
  a_type_sub: assert property (p_type_sub) else $error("sub type wrong");

  property p_type_resv;
    @(posedge hclk) disable iff (!hresetn)
    rd_type |=> hrdata[31:8] == 24'h0;
  endproperty
  a_type_resv: assert property (p_type_resv) else $error("type reserved set");

  property p_id4_size;
    @(posedge hclk) disable iff (!hresetn)
    rd_id4 |=> hrdata[7:4] == 4'h0;
  endproperty
  a_id4_size: assert property (p_id4_size) else $error("id4 size wrong");

  property p_id4_cont;
    @(posedge hclk) disable iff (!hresetn)
    rd_id4 |=> hrdata[3:0] == CONT_CODE;
  endproperty
  a_id4_cont: assert property (p_id4_cont) else $error("id4 code wrong");

  property p_id4_resv;
    @(posedge hclk) disable iff (!hresetn)
    rd_id4 |=> hrdata[31:8] == 24'h0;
  endproperty
  a_id4_resv: assert property (p_id4_resv) else $error("id4 reserved set");

  property p_id5_zero;
    @(posedge hclk) disable iff (!hresetn)
    rd_id5 |=> hrdata == 32'h0;
  endproperty
  a_id5_zero: assert property (p_id5_zero) else $error("id5 nonzero");

  property p_id6_zero;
    @(posedge hclk) disable iff (!hresetn)
    rd_id6 |=> hrdata == 32'h0;
  endproperty
  a_id6_zero: assert property (p_id6_zero) else $error("id6 nonzero");

  property p_id7_zero;
    @(posedge hclk) disable iff (!hresetn)
    rd_id7 |=> hrdata == 32'h0;
  endproperty
  a_id7_zero: assert property (p_id7_zero) else $error("id7 nonzero");

  property p_id0_part;
    @(posedge hclk) disable iff (!hresetn)
    rd_id0 |=> hrdata[7:0] == PART_LOW;
  endproperty
  a_id0_part: assert property (p_id0_part) else $error("id0 part wrong");

  property p_id0_resv;
    @(posedge hclk) disable iff (!hresetn)
    rd_id0 |=> hrdata[31:8] == 24'h0;
  endproperty
  a_id0_resv: assert property (p_id0_resv) else $error("id0 reserved set");

  property p_unmap_zero;
    @(posedge hclk) disable iff (!hresetn)
    rd_unmapped |=> hrdata == 32'h0;
  endproperty
  a_unmap_zero: assert property (p_unmap_zero) else $error("unmapped nonzero");

  // ----------------------------------------
  // Handshake and clock enable
  // ----------------------------------------
  // A transfer lost during a freeze would hang the master, so these guard the stall
  property p_read_done;
    @(posedge hclk) disable iff (!hresetn)
    rd_fire |=> hreadyout == clk_en;
  endproperty
  a_read_done: assert property (p_read_done) else $error("read not done");

  property p_addr_align;
    @(posedge hclk) disable iff (!hresetn)
    s_q.addr[1:0] == 2'b00;
  endproperty
  a_addr_align: assert property (p_addr_align) else $error("address unaligned");

  property p_no_take;
    @(posedge hclk) disable iff (!hresetn)
    s_q.rd_pend |-> !valid_req;
  endproperty
  a_no_take: assert property (p_no_take) else $error("taken while busy");

  property p_stall_rdy;
    @(posedge hclk) disable iff (!hresetn)
    !clk_en |-> !hreadyout;
  endproperty
  a_stall_rdy: assert property (p_stall_rdy) else $error("ready while frozen");

  property p_freeze;
    @(posedge hclk) disable iff (!hresetn)
    !clk_en |=> $stable(s_q);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved frozen");

  property p_write_clr;
    @(posedge hclk) disable iff (!hresetn)
    (clk_en && valid_req && hwrite) |=> hrdata == 32'h0;
  endproperty
  a_write_clr: assert property (p_write_clr) else $error("write left data");

  property p_write_keep;
    @(posedge hclk) disable iff (!hresetn)
    (clk_en && valid_req && hwrite) |=> !s_q.rd_pend;
  endproperty
  a_write_keep: assert property (p_write_keep) else $error("write opened read");

  property p_idle_hold;
    @(posedge hclk) disable iff (!hresetn)
    (!valid_req && !s_q.rd_pend) |=> $stable(hrdata);
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("idle data moved");

  c_read: cover property (@(posedge hclk) valid_req && !hwrite ##2 hreadyout);
  c_write: cover property (@(posedge hclk) valid_req && hwrite);
  c_b2b: cover property (@(posedge hclk) valid_req && !hwrite ##3 valid_req && !hwrite);
  c_stall: cover property (@(posedge hclk) !clk_en && s_q.rd_pend);
  c_unmapped: cover property (@(posedge hclk) rd_unmapped);
endmodule

// ==== src/tpid_pkg.sv ====
// Package of offsets, field positions and fixed values of the trace port identification registers
package tpid_pkg;
  // ----------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [11:0] TPID_OFS_DEVICE_CAPABILITIES = 12'hfc8;
  localparam logic [11:0] TPID_OFS_DEVICE_TYPE_CODE = 12'hfcc;
  localparam logic [11:0] TPID_OFS_PERIPHERAL_IDENT_WORD4 = 12'hfd0;
  localparam logic [11:0] TPID_OFS_PERIPHERAL_IDENT_WORD5 = 12'hfd4;
  localparam logic [11:0] TPID_OFS_PERIPHERAL_IDENT_WORD6 = 12'hfd8;
  localparam logic [11:0] TPID_OFS_PERIPHERAL_IDENT_WORD7 = 12'hfdc;
  localparam logic [11:0] TPID_OFS_PERIPHERAL_IDENT_WORD0 = 12'hfe0;
  localparam int TPID_ADDR_W = 12;
  // ----------------------------------------
  // Capability word field positions
  // ----------------------------------------
  localparam int TPID_POS_PARALLEL_PRESCALER_FLAG = 17;
  localparam int TPID_POS_SERIAL_NRZ_SUPPORTED = 11;
  localparam int TPID_POS_SERIAL_MANCHESTER_SUPPORTED = 10;
  localparam int TPID_POS_PARALLEL_PORT_UNSUPPORTED = 9;
  localparam int TPID_POS_OUTPUT_FIFO_DEPTH_CODE = 6;
  localparam int TPID_POS_CLOCK_RELATION_FLAG = 5;
  localparam int TPID_POS_INPUT_MUX_COUNT = 0;
  // ----------------------------------------
  // Capability word field values
  // ----------------------------------------
  localparam logic TPID_VAL_PARALLEL_PRESCALER_FLAG = 1'b1;
  localparam logic TPID_VAL_SERIAL_NRZ_SUPPORTED = 1'b1;
  localparam logic TPID_VAL_SERIAL_MANCHESTER_SUPPORTED = 1'b1;
  localparam logic TPID_VAL_PARALLEL_PORT_UNSUPPORTED = 1'b0;
  localparam logic [2:0] TPID_VAL_OUTPUT_FIFO_DEPTH_CODE = 3'h0;
  localparam logic TPID_VAL_CLOCK_RELATION_FLAG = 1'b1;
  localparam logic [4:0] TPID_VAL_INPUT_MUX_COUNT = 5'h00;
  // ----------------------------------------
  // Other fixed words
  // ----------------------------------------
  localparam logic [31:0] TPID_VAL_DEVICE_TYPE_CODE = 32'h0000_0011;
  localparam logic [3:0] TPID_VAL_ID4_SIZE = 4'h0;
  localparam int TPID_POS_ID4_SIZE = 4;
  localparam logic [31:0] TPID_VAL_ZERO = 32'h0000_0000;
  // ----------------------------------------
  // AHB-Lite encodings
  // ----------------------------------------
  localparam logic [1:0] TPID_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] TPID_HTRANS_SEQ = 2'h3;
endpackage

// ==== src/tpid_rd_if.sv ====
// Read request and answer between the bus slave and the register file
`timescale 1ns/1ns
interface tpid_rd_if;
  logic [11:0] addr;
  logic [31:0] data;
  logic hit;
  modport bus (output addr, input data, input hit);
  modport regs (input addr, output data, output hit);
endinterface

// ==== src/tpid_regfile.sv ====
// Fixed identification values decoded by address
`timescale 1ns/1ns
module tpid_regfile
  import tpid_pkg::*;
#(
  parameter logic [3:0] CONT_CODE = 4'h0,  // Arbitrary value
  parameter logic [7:0] PART_LOW = 8'h00   // Arbitrary value
) (
  tpid_rd_if.regs rd
);
  // ----------------------------------------
  // Word values
  // ----------------------------------------
  function automatic logic [31:0] cap_word();
    logic [31:0] w;
    w = TPID_VAL_ZERO;
    w[TPID_POS_PARALLEL_PRESCALER_FLAG] = TPID_VAL_PARALLEL_PRESCALER_FLAG
                                          & ~TPID_VAL_PARALLEL_PORT_UNSUPPORTED;
    w[TPID_POS_SERIAL_NRZ_SUPPORTED] = TPID_VAL_SERIAL_NRZ_SUPPORTED;
    w[TPID_POS_SERIAL_MANCHESTER_SUPPORTED] = TPID_VAL_SERIAL_MANCHESTER_SUPPORTED;
    w[TPID_POS_PARALLEL_PORT_UNSUPPORTED] = TPID_VAL_PARALLEL_PORT_UNSUPPORTED;
    w[TPID_POS_OUTPUT_FIFO_DEPTH_CODE +: 3] = TPID_VAL_OUTPUT_FIFO_DEPTH_CODE;
    w[TPID_POS_CLOCK_RELATION_FLAG] = TPID_VAL_CLOCK_RELATION_FLAG;
    w[TPID_POS_INPUT_MUX_COUNT +: 5] = TPID_VAL_INPUT_MUX_COUNT;
    return w;
  endfunction

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  always_comb begin
    rd.hit = 1'b1;
    rd.data = TPID_VAL_ZERO;
    if (rd.addr == TPID_OFS_DEVICE_CAPABILITIES) begin
      rd.data = cap_word();
    end else if (rd.addr == TPID_OFS_DEVICE_TYPE_CODE) begin
      rd.data = TPID_VAL_DEVICE_TYPE_CODE;
    end else if (rd.addr == TPID_OFS_PERIPHERAL_IDENT_WORD4) begin
      rd.data = {24'h000000, TPID_VAL_ID4_SIZE, CONT_CODE};
    end else if (rd.addr == TPID_OFS_PERIPHERAL_IDENT_WORD5 ||
                 rd.addr == TPID_OFS_PERIPHERAL_IDENT_WORD6 ||
                 rd.addr == TPID_OFS_PERIPHERAL_IDENT_WORD7) begin
      rd.data = TPID_VAL_ZERO;
    end else if (rd.addr == TPID_OFS_PERIPHERAL_IDENT_WORD0) begin
      rd.data = {24'h000000, PART_LOW};
    end else begin
      rd.hit = 1'b0;
    end
  end
endmodule

// ==== test/tpid_top_test.sv ====
// Self-checking bench for the trace port identification registers
`timescale 1ns/1ns
`define CHK(nm, ex, gt) begin comparisons++; if ((gt) !== (ex)) begin error_cnt++; \
  $display("MISMATCH %s expected %h seen %h", nm, ex, gt); end end
module tpid_top_test;
  import tpid_pkg::*;
  localparam logic [3:0] CC = 4'h7;  // Arbitrary continuation code
  localparam logic [7:0] PL = 8'h3c; // Arbitrary part number low byte
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic clk_en = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic [31:0] lfsr = 32'hdb83;
  logic [31:0] exp_q[$];
  int error_cnt = 0;
  int comparisons = 0;
  int cyc = 0;

  always #2 hclk = ~hclk;

  // One slave, so its ready is the bus ready
  tpid_top #(.CONT_CODE(CC), .PART_LOW(PL)) dut (.hclk(hclk), .hresetn(hresetn),
    .clk_en(clk_en), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata));

  // ----------------------------------------
  // Model and helpers
  // ----------------------------------------
  function automatic logic [31:0] lfsr_next(logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  // Fixed words; writes never change them, so no state is kept
  function automatic logic [31:0] model_word(logic [31:0] a);
    int v;
    v = 0;
    case ({a[11:2], 2'b00})
      12'hfc8: v = (1 << 17) | (1 << 11) | (1 << 10) | (1 << 5);
      12'hfcc: v = 'h11;
      12'hfd0: v = int'(CC);
      12'hfe0: v = int'(PL);
      default: v = 0;
    endcase
    return v[31:0];
  endfunction

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Single AHB-Lite word transfer; waits for ready in both phases
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    logic [31:0] ex;
    hsel <= 1'b1;
    htrans <= TPID_HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= w;
    hsize <= 3'h2;
    if (!w) begin
      exp_q.push_back(model_word(a));
    end
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    `CHK("hresp", 1'b0, hresp)
    if (!w) begin
      ex = exp_q.pop_front();
      `CHK("hrdata", ex, rd)
    end
  endtask

  always @(posedge hclk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      stop_test();
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge hclk);
    `CHK("reset hreadyout", 1'b1, hreadyout)
    `CHK("reset hrdata", 32'h0000_0000, hrdata)
    hresetn <= 1'b1;
    @(posedge hclk);
    $display("test reset done");
    ahb(1'b0, 32'h0000_0fc8, 32'h0);
    `CHK("prescaler flag", 1'b1, rd[17])
    `CHK("nrz flag", 1'b1, rd[11])
    `CHK("manchester flag", 1'b1, rd[10])
    `CHK("parallel unsupported", 1'b0, rd[9])
    `CHK("fifo depth", 3'h0, rd[8:6])
    `CHK("clock relation", 1'b1, rd[5])
    `CHK("mux count", 5'h00, rd[4:0])
    `CHK("cap reserved", 19'h00000, {rd[31:18], rd[16:12]})
    ahb(1'b0, 32'h0000_0fcc, 32'h0);
    `CHK("type word", 32'h0000_0011, rd)
    ahb(1'b0, 32'h0000_0fd0, 32'h0);
    `CHK("id4 size", 4'h0, rd[7:4])
    `CHK("id4 cont", CC, rd[3:0])
    `CHK("id4 reserved", 24'h000000, rd[31:8])
    ahb(1'b0, 32'h0000_0fe0, 32'h0);
    `CHK("id0 part", PL, rd[7:0])
    for (int i = 0; i < 3; i++) begin
      ahb(1'b0, 32'h0000_0fd4 + 32'(4 * i), 32'h0);
      `CHK("id5 to 7", 32'h0000_0000, rd)
    end
    $display("test field values done");
    // Freeze across a read; the master only waits longer
    fork
      ahb(1'b0, 32'h0000_0fcc, 32'h0);
      begin
        @(posedge hclk);
        clk_en <= 1'b0;
        repeat (3) @(posedge hclk);
        clk_en <= 1'b1;
      end
    join
    `CHK("type word frozen", 32'h0000_0011, rd)
    $display("test clock enable done");
    // Random writes and reads, mirrored and unmapped places included
    for (int i = 0; i < 60; i++) begin
      lfsr = lfsr_next(lfsr);
      ahb(lfsr[4], {lfsr[31:12], lfsr[5] ? {lfsr[11:2], 2'b00} : {6'h3f, lfsr[3:0], 2'b00}},
        lfsr_next(lfsr) & 32'h0000_00ff);
    end
    for (int i = 0; i < 7; i++) begin
      ahb(1'b0, 32'h0000_0fc8 + 32'(4 * i), 32'h0);
    end
    $display("test random traffic done");
    stop_test();
  end
endmodule
